// *** rtl/fslg_pkg.sv ***
package fslg_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] COMMAND_OFS = 8'h04;
  localparam logic [7:0] CONTROL_OFS = 8'h08;

  // status fields: the lock code sits where software expects it
  localparam int ST_LOCK_LSB = 5;
  localparam int ST_LEVEL_LSB = 8;
  localparam int ST_BLK0_LSB = 10;
  localparam int ST_BLK1_LSB = 12;
  localparam int ST_VERIFY_BIT = 14;
  localparam int ST_BOOT_EXT_BIT = 15;
  localparam int ST_HOST_BIT = 16;

  // command word fields
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_BLK_BIT = 8;
  localparam int CMD_ACC_BIT = 14;
  localparam int CMD_REF_BIT = 15;

  // control fields
  localparam int CTRL_IAP_EN_BIT = 0;

  // ------------------------------------------------------------
  // mailbox command codes
  // ------------------------------------------------------------
  localparam logic [6:0] CMD_CHIP_ERASE = 7'h01;
  localparam logic [6:0] CMD_BLOCK_ERASE = 7'h0D;
  localparam logic [6:0] CMD_SECTOR_ERASE = 7'h0B;
  localparam logic [6:0] CMD_BYTE_PROG = 7'h0E;
  localparam logic [6:0] CMD_BURST_PROG = 7'h06;
  localparam logic [6:0] CMD_BYTE_VERIFY = 7'h0C;
  localparam logic [6:0] CMD_PROG_LB3 = 7'h05;
  localparam logic [6:0] CMD_PROG_LB2 = 7'h03;
  localparam logic [6:0] CMD_PROG_LB1 = 7'h0F;

  // ------------------------------------------------------------
  // reset values and bus answers
  // ------------------------------------------------------------
  // cell state: 0 = programmed, 1 = erased
  localparam logic [2:0] CELLS_ERASED = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [7:0] TBL_BLOCKED_DATA = 8'hFF;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    LOCK_NONE = 2'b00,
    LOCK_HARD = 2'b01,
    LOCK_SOFT = 2'b10
  } fslg_lock_type;

  typedef enum logic [1:0] {
    LEVEL_1 = 2'b00,
    LEVEL_2 = 2'b01,
    LEVEL_3 = 2'b10,
    LEVEL_4 = 2'b11
  } fslg_level_type;

  typedef enum logic [1:0] {
    REGION_BLK0 = 2'b00,
    REGION_BLK1 = 2'b01,
    REGION_EXT = 2'b10
  } fslg_region_type;

endpackage : fslg_pkg

// *** rtl/fslg_level_decode.sv ***
`timescale 1ns/1ps
module fslg_level_decode (
  input wire logic [2:0] i_cells,           // stored cells, 0 = programmed
  output logic [2:0] o_lock_code,           // code as software reads it
  output fslg_pkg::fslg_level_type o_level, // security level
  output fslg_pkg::fslg_lock_type o_blk0,   // primary block lock
  output fslg_pkg::fslg_lock_type o_blk1,   // secondary block lock
  output logic o_verify_ok                  // byte verify permitted
);
  import fslg_pkg::*;

  // a programmed cell reads as 1 in the status code
  assign o_lock_code = ~i_cells;

  // ------------------------------------------------------------
  // level decode, purely combinational so new bits act at once
  // ------------------------------------------------------------
  always_comb begin
    o_verify_ok = 1'b0;
    o_level = LEVEL_4;
    o_blk0 = LOCK_HARD;
    o_blk1 = LOCK_HARD;
    unique case (o_lock_code)
      3'b000: begin
        o_level = LEVEL_1;
        o_blk0 = LOCK_NONE;
        o_blk1 = LOCK_NONE;
        o_verify_ok = 1'b1;
      end
      3'b100: begin
        o_level = LEVEL_2;
        o_verify_ok = 1'b1;
      end
      3'b110, 3'b101: begin
        o_level = LEVEL_3;
      end
      3'b010: begin
        o_level = LEVEL_3;
        o_blk0 = LOCK_SOFT;
        o_blk1 = LOCK_SOFT;
      end
      3'b001: begin
        o_level = LEVEL_3;
        o_blk0 = LOCK_SOFT;
      end
      // 111 and the unused 011 land on the strictest level
      default: begin
        o_level = LEVEL_4;
      end
    endcase
  end

endmodule : fslg_level_decode

// *** rtl/fslg_lock_gate.sv ***
`timescale 1ns/1ps
module fslg_lock_gate #(
  parameter logic [2:0] P_CELLS_INIT = 3'h7 // cell state loaded at reset
) (
  input wire logic i_core_clk,              // core clock, 40 MHz
  input wire logic i_rst_n,                 // synchronous reset, low
  // axi4-lite slave
  input wire logic [7:0] i_s_axi_awaddr,    // write address
  input wire logic i_s_axi_awvalid,         // write address valid
  output logic o_s_axi_awready,             // write address ready
  input wire logic [31:0] i_s_axi_wdata,    // write data
  input wire logic [3:0] i_s_axi_wstrb,     // write byte strobes
  input wire logic i_s_axi_wvalid,          // write data valid
  output logic o_s_axi_wready,              // write data ready
  output logic [1:0] o_s_axi_bresp,         // write response
  output logic o_s_axi_bvalid,              // write response valid
  input wire logic i_s_axi_bready,          // write response ready
  input wire logic [7:0] i_s_axi_araddr,    // read address
  input wire logic i_s_axi_arvalid,         // read address valid
  output logic o_s_axi_arready,             // read address ready
  output logic [31:0] o_s_axi_rdata,        // read data
  output logic [1:0] o_s_axi_rresp,         // read response
  output logic o_s_axi_rvalid,              // read data valid
  input wire logic i_s_axi_rready,          // read data ready
  // core fetch path
  input wire logic [1:0] i_fetch_region,    // region running the code
  input wire logic i_tbl_req,               // table read request
  input wire logic [1:0] i_tbl_src,         // region of the read opcode
  input wire logic [1:0] i_tbl_tgt,         // region being read
  input wire logic [7:0] i_tbl_raw,         // raw byte from the array
  output logic o_tbl_allow,                 // current read permitted
  output logic o_tbl_valid,                 // table data ready pulse
  output logic [7:0] o_tbl_data,            // gated table byte
  // external programmer
  input wire logic i_host_mode,             // host programming mode
  input wire logic i_host_cmd_valid,        // host command strobe
  input wire logic [6:0] i_host_cmd_code,   // host command code
  input wire logic i_host_cmd_blk,          // host target, 1 = secondary
  // pin and flash engine
  input wire logic i_ext_access_n,          // external access pin, low
  output logic o_boot_external,             // boot from external memory
  output logic o_flash_cmd_valid,           // granted command pulse
  output logic [6:0] o_flash_cmd_code,      // granted command code
  output logic o_flash_cmd_blk,             // granted target block
  output logic o_flash_cmd_host,            // granted from host
  output logic o_remap_erase,               // erase remap bits pulse
  output logic o_cmd_refused                // refused command pulse
);
  import fslg_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [2:0] cells;
  logic [2:0] lock_code;
  fslg_level_type level;
  fslg_lock_type blk0_lock;
  fslg_lock_type blk1_lock;
  logic verify_ok;
  logic iap_en;
  logic cmd_acc;
  logic cmd_ref;
  logic [6:0] last_code;
  logic last_blk;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic iap_req;
  logic req_valid;
  logic [6:0] req_code;
  logic req_tgt;
  logic req_host;
  fslg_region_type req_src;
  fslg_lock_type tgt_lock;
  fslg_lock_type eff_lock;
  logic src_other;
  logic req_ok;
  logic ea_s1;
  logic ea_s2;
  logic ea_s3;
  logic ea_stable;
  logic [2:0] ea_fill;
  logic ea_armed;
  logic ea_latched;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // ------------------------------------------------------------
  // level decoder
  // ------------------------------------------------------------
  fslg_level_decode u_decode (
    .i_cells(cells),
    .o_lock_code(lock_code),
    .o_level(level),
    .o_blk0(blk0_lock),
    .o_blk1(blk1_lock),
    .o_verify_ok(verify_ok)
  );

  // ------------------------------------------------------------
  // lock cells
  // ------------------------------------------------------------
  // cells model the non-volatile bits; only a granted command
  // moves them, so the decode follows on the very next cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cells <= P_CELLS_INIT;
    end else if (req_valid && req_ok) begin
      if (req_code == CMD_CHIP_ERASE) begin
        cells <= CELLS_ERASED;
      end else if (req_code == CMD_PROG_LB1) begin
        cells[2] <= 1'b0;
      end else if (req_code == CMD_PROG_LB2) begin
        cells[1] <= 1'b0;
      end else if (req_code == CMD_PROG_LB3) begin
        cells[0] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // external access pin
  // ------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ea_s1 <= 1'b1;
      ea_s2 <= 1'b1;
      ea_s3 <= 1'b1;
      ea_stable <= 1'b1;
      ea_fill <= 3'h0;
    end else begin
      ea_fill <= {ea_fill[1:0], 1'b1}; // stages holding real pin samples
      ea_s1 <= i_ext_access_n;
      ea_s2 <= ea_s1;
      ea_s3 <= ea_s2;
      if (ea_s2 == ea_s3) begin
        ea_stable <= ea_s3;
      end
    end
  end

  // pin is caught once after release; the wait lets the
  // synchroniser fill before the value is trusted
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ea_armed <= 1'b0;
      ea_latched <= 1'b0;
    end else if (!ea_armed && ea_fill[2] && ea_s2 == ea_s3
                 && ea_s3 == ea_stable) begin
      ea_armed <= 1'b1;
      ea_latched <= ~ea_stable;
    end
  end

  // the strictest level always boots from internal memory
  assign o_boot_external = ea_latched && (level != LEVEL_4);

  // ------------------------------------------------------------
  // command arbitration
  // ------------------------------------------------------------
  // host and mailbox never compete: host mode shuts the mailbox
  assign iap_req = wr_fire && (aw_addr == COMMAND_OFS) && w_strb[0]
                   && iap_en && !i_host_mode;

  always_comb begin
    req_valid = iap_req || (i_host_mode && i_host_cmd_valid);
    req_host = i_host_mode;
    if (i_host_mode) begin
      req_code = i_host_cmd_code;
      req_tgt = i_host_cmd_blk;
      req_src = REGION_EXT;
    end else begin
      req_code = w_data[CMD_CODE_LSB +: 7];
      req_tgt = w_data[CMD_BLK_BIT] && w_strb[1];
      req_src = fslg_region_type'(i_fetch_region);
    end
  end

  // ------------------------------------------------------------
  // command permission
  // ------------------------------------------------------------
  always_comb begin
    tgt_lock = req_tgt ? blk1_lock : blk0_lock;
    // code in the other internal block may work on a soft block
    src_other = (req_src == REGION_BLK0 && req_tgt)
                || (req_src == REGION_BLK1 && !req_tgt);
    if (req_host && tgt_lock == LOCK_SOFT) begin
      eff_lock = LOCK_HARD;
    end else begin
      eff_lock = tgt_lock;
    end
    req_ok = 1'b0;
    if (req_code == CMD_CHIP_ERASE) begin
      req_ok = 1'b1;
    end else if (req_code == CMD_PROG_LB1 || req_code == CMD_PROG_LB2
                 || req_code == CMD_PROG_LB3) begin
      req_ok = 1'b1;
    end else if (req_code == CMD_BYTE_VERIFY) begin
      // host verify survives a hard lock only at level two
      req_ok = (eff_lock == LOCK_NONE)
               || (req_host && verify_ok)
               || (eff_lock == LOCK_SOFT && src_other);
    end else if (req_code == CMD_BLOCK_ERASE
                 || req_code == CMD_SECTOR_ERASE
                 || req_code == CMD_BYTE_PROG
                 || req_code == CMD_BURST_PROG) begin
      req_ok = (eff_lock == LOCK_NONE)
               || (eff_lock == LOCK_SOFT && src_other);
    end
  end

  // granted commands go to the flash engine as one-cycle pulses
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_flash_cmd_valid <= 1'b0;
      o_flash_cmd_code <= 7'h00;
      o_flash_cmd_blk <= 1'b0;
      o_flash_cmd_host <= 1'b0;
      o_remap_erase <= 1'b0;
      o_cmd_refused <= 1'b0;
    end else begin
      o_flash_cmd_valid <= req_valid && req_ok;
      o_remap_erase <= req_valid && req_ok
                       && req_code == CMD_CHIP_ERASE;
      o_cmd_refused <= req_valid && !req_ok;
      if (req_valid) begin
        o_flash_cmd_code <= req_code;
        o_flash_cmd_blk <= req_tgt;
        o_flash_cmd_host <= req_host;
      end
    end
  end

  // outcome of the latest command stays readable until the next
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cmd_acc <= 1'b0;
      cmd_ref <= 1'b0;
      last_code <= 7'h00;
      last_blk <= 1'b0;
    end else if (req_valid) begin
      cmd_acc <= req_ok;
      cmd_ref <= !req_ok;
      last_code <= req_code;
      last_blk <= req_tgt;
    end
  end

  // ------------------------------------------------------------
  // table read gate
  // ------------------------------------------------------------
  // external code may not look into any locked block; internal
  // code is stopped only by a hard lock it does not share
  always_comb begin
    fslg_lock_type rd_tgt;
    fslg_lock_type rd_src;
    rd_tgt = (i_tbl_tgt == REGION_BLK1) ? blk1_lock : blk0_lock;
    rd_src = (i_tbl_src == REGION_BLK1) ? blk1_lock : blk0_lock;
    if (i_tbl_tgt == REGION_EXT || rd_tgt == LOCK_NONE) begin
      o_tbl_allow = 1'b1;
    end else if (i_tbl_src == REGION_EXT) begin
      o_tbl_allow = 1'b0;
    end else if (rd_tgt == LOCK_HARD) begin
      o_tbl_allow = (rd_src == LOCK_HARD);
    end else begin
      o_tbl_allow = 1'b1;
    end
  end

  // blocked reads return a fixed byte, never the array contents
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_tbl_valid <= 1'b0;
      o_tbl_data <= 8'h00;
    end else begin
      o_tbl_valid <= i_tbl_req;
      if (i_tbl_req) begin
        o_tbl_data <= o_tbl_allow ? i_tbl_raw : TBL_BLOCKED_DATA;
      end
    end
  end

  // ------------------------------------------------------------
  // axi4-lite write channels
  // ------------------------------------------------------------
  // address and data are taken in either order; no new beat is
  // taken while a response waits, which keeps one write in flight
  assign o_s_axi_awready = !aw_got && !o_s_axi_bvalid;
  assign o_s_axi_wready = !w_got && !o_s_axi_bvalid;
  assign wr_fire = aw_got && w_got && !o_s_axi_bvalid;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      aw_got <= 1'b0;
      aw_addr <= 8'h00;
    end else if (wr_fire) begin
      aw_got <= 1'b0;
    end else if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_got <= 1'b1;
      aw_addr <= {i_s_axi_awaddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      w_got <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wr_fire) begin
      w_got <= 1'b0;
    end else if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_got <= 1'b1;
      w_data <= i_s_axi_wdata;
      w_strb <= i_s_axi_wstrb;
    end
  end

  // write response; status is read-only and answers okay
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      o_s_axi_bvalid <= 1'b1;
      if (aw_addr == STATUS_OFS || aw_addr == COMMAND_OFS
          || aw_addr == CONTROL_OFS) begin
        o_s_axi_bresp <= RESP_OKAY;
      end else begin
        o_s_axi_bresp <= RESP_DECERR;
      end
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // control register: mailbox enable
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      iap_en <= 1'b0;
    end else if (wr_fire && aw_addr == CONTROL_OFS && w_strb[0]) begin
      iap_en <= w_data[CTRL_IAP_EN_BIT];
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read channels
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = RESP_OKAY;
    if (i_s_axi_araddr[7:2] == STATUS_OFS[7:2]) begin
      next_rdata[ST_LOCK_LSB +: 3] = lock_code;
      next_rdata[ST_LEVEL_LSB +: 2] = level;
      next_rdata[ST_BLK0_LSB +: 2] = blk0_lock;
      next_rdata[ST_BLK1_LSB +: 2] = blk1_lock;
      next_rdata[ST_VERIFY_BIT] = verify_ok;
      next_rdata[ST_BOOT_EXT_BIT] = o_boot_external;
      next_rdata[ST_HOST_BIT] = i_host_mode;
    end else if (i_s_axi_araddr[7:2] == COMMAND_OFS[7:2]) begin
      next_rdata[CMD_CODE_LSB +: 7] = last_code;
      next_rdata[CMD_BLK_BIT] = last_blk;
      next_rdata[CMD_ACC_BIT] = cmd_acc;
      next_rdata[CMD_REF_BIT] = cmd_ref;
    end else if (i_s_axi_araddr[7:2] == CONTROL_OFS[7:2]) begin
      next_rdata[CTRL_IAP_EN_BIT] = iap_en;
    end else begin
      next_rresp = RESP_DECERR;
    end
  end

  // one read in flight; the address is refused while data waits
  assign o_s_axi_arready = !o_s_axi_rvalid;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= next_rdata;
      o_s_axi_rresp <= next_rresp;
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

endmodule : fslg_lock_gate

// *** sim/fslg_lock_gate_properties.sv ***
`timescale 1ns/1ps
module fslg_lock_gate_props (
  input wire logic i_core_clk, // clock
  input wire logic i_rst_n, // reset, low
  input wire logic i_tbl_req, // table request
  input wire logic [1:0] i_tbl_tgt, // region read
  input wire logic [7:0] i_tbl_raw, // array byte
  input wire logic o_tbl_allow, // read allowed
  input wire logic [7:0] o_tbl_data, // gated byte
  input wire logic o_tbl_valid, // data pulse
  input wire logic i_host_mode, // host mode
  input wire logic i_host_cmd_valid, // host strobe
  input wire logic [6:0] i_host_cmd_code, // host code
  input wire logic o_flash_cmd_valid, // grant pulse
  input wire logic [6:0] o_flash_cmd_code, // granted code
  input wire logic o_remap_erase, // remap erase
  input wire logic o_cmd_refused // refuse pulse
);
  import fslg_pkg::*;
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking dc @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  // each table request answers on the next cycle
  a_tbl_pulse: assert property (i_tbl_req |=> o_tbl_valid)
    else $error("table read got no data pulse");
  // a refused read must never leak the array byte
  a_tbl_block: assert property (
    i_tbl_req && !o_tbl_allow |=> o_tbl_data == TBL_BLOCKED_DATA)
    else $error("blocked table read leaked data");
  a_tbl_pass: assert property (
    i_tbl_req && o_tbl_allow |=> o_tbl_data == $past(i_tbl_raw))
    else $error("allowed table read lost data");
  // external memory is never guarded by the flash locks
  a_ext_open: assert property (
    i_tbl_req && i_tbl_tgt == REGION_EXT |-> o_tbl_allow)
    else $error("external table read refused");
  a_host_answer: assert property (
    i_host_mode && i_host_cmd_valid |=> (o_flash_cmd_valid ^ o_cmd_refused)
    && o_flash_cmd_code == $past(i_host_cmd_code))
    else $error("host command not answered once");
  a_erase_free: assert property (
    i_host_mode && i_host_cmd_valid && i_host_cmd_code == CMD_CHIP_ERASE
    |=> o_flash_cmd_valid && o_remap_erase)
    else $error("chip erase not granted");
  a_remap_cause: assert property (
    o_remap_erase |-> o_flash_cmd_valid && o_flash_cmd_code == CMD_CHIP_ERASE)
    else $error("remap erase without chip erase");
  a_one_verdict: assert property (o_cmd_refused |-> !o_flash_cmd_valid
    && o_flash_cmd_code != CMD_CHIP_ERASE) else $error("chip erase refused");

  c_tbl_deny: cover property (i_tbl_req && !o_tbl_allow);
  c_refused: cover property (o_cmd_refused);
  c_remap: cover property (o_remap_erase);
endmodule : fslg_lock_gate_props

// *** sim/fslg_array_model.sv ***
`timescale 1ns/1ps
module fslg_array_model (
  input wire logic i_req, // table request
  input wire logic [1:0] i_tgt, // region read
  input wire logic [23:0] i_fill, // byte of each region
  output logic [7:0] o_raw // byte offered to the gate
);
  // outside a request the array lines are not driven: show the inverse
  // so that a stale byte can never pass for a good one
  always_comb begin
    o_raw = i_fill[i_tgt * 8 +: 8];
    if (!i_req) begin
      o_raw = ~o_raw;
    end
  end
endmodule : fslg_array_model

// *** sim/flash_security_lock_gate_test.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module flash_security_lock_gate_test;
  import fslg_pkg::*;
  logic i_core_clk, i_rst_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
  logic i_s_axi_arvalid, i_s_axi_rready, o_s_axi_awready, o_s_axi_wready;
  logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, i_tbl_req;
  logic o_tbl_allow, o_tbl_valid, i_host_mode, i_host_cmd_valid, b, ok;
  logic i_host_cmd_blk, i_ext_access_n, o_boot_external, o_flash_cmd_valid;
  logic o_flash_cmd_blk, o_flash_cmd_host, o_remap_erase, o_cmd_refused;
  logic [7:0] i_s_axi_awaddr, i_s_axi_araddr, i_tbl_raw, o_tbl_data;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
  logic [3:0] i_s_axi_wstrb;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, i_fetch_region, i_tbl_src;
  logic [1:0] i_tbl_tgt, s;
  logic [6:0] i_host_cmd_code, o_flash_cmd_code, code;
  logic [23:0] fill;
  logic [10:0] st;
  logic [12:0] ev;
  logic [12:0] rdq[$], cmq[$];
  logic [7:0] tbq[$];
  int miscompares, num_checks;

  fslg_lock_gate dut_u (.*);
  fslg_array_model arr_u (.i_req(i_tbl_req), .i_tgt(i_tbl_tgt),
    .i_fill(fill), .o_raw(i_tbl_raw));

  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  // ------------------------------------------------------------
  // expectations: status bits 15 to 5 for a lock code
  // ------------------------------------------------------------
  function automatic logic [10:0] exp_st(input logic [2:0] c);
    logic [1:0] lv, b0, b1;
    logic v;
    case (c)
      3'h0: {lv, b0, b1, v} = {LEVEL_1, LOCK_NONE, LOCK_NONE, 1'b1};
      3'h4: {lv, b0, b1, v} = {LEVEL_2, LOCK_HARD, LOCK_HARD, 1'b1};
      3'h6, 3'h5: {lv, b0, b1, v} = {LEVEL_3, LOCK_HARD, LOCK_HARD, 1'b0};
      3'h2: {lv, b0, b1, v} = {LEVEL_3, LOCK_SOFT, LOCK_SOFT, 1'b0};
      3'h1: {lv, b0, b1, v} = {LEVEL_3, LOCK_SOFT, LOCK_HARD, 1'b0};
      default: {lv, b0, b1, v} = {LEVEL_4, LOCK_HARD, LOCK_HARD, 1'b0};
    endcase
    return {lv != LEVEL_4 && !i_ext_access_n, v, b1, b0, lv, c};
  endfunction : exp_st

  function automatic logic [1:0] lk(input logic blk);
    return blk ? st[8:7] : st[6:5];
  endfunction : lk

  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic aw = 1'b1, w = 1'b1;
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge i_core_clk);
      if (aw && o_s_axi_awready) begin
        aw = 1'b0;
        i_s_axi_awvalid <= 1'b0;
      end
      if (w && o_s_axi_wready) begin
        w = 1'b0;
        i_s_axi_wvalid <= 1'b0;
      end
    end
    i_s_axi_bready <= 1'b1;
    do @(posedge i_core_clk); while (!o_s_axi_bvalid);
    `CHK("bresp", er, o_s_axi_bresp)
    i_s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [12:0] e);
    rdq.push_back(e);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    do @(posedge i_core_clk); while (!o_s_axi_arready);
    i_s_axi_arvalid <= 1'b0;
    i_s_axi_rready <= 1'b1;
    do @(posedge i_core_clk); while (!o_s_axi_rvalid);
    i_s_axi_rready <= 1'b0;
  endtask : rd

  task automatic mbox(input logic [1:0] src, input logic [6:0] c,
    input logic blk, input logic g);
    i_fetch_region <= src;
    cmq.push_back({3'h0, 1'b0, blk, g, c});
    wr(COMMAND_OFS, {23'h0, blk, 1'b0, c}, RESP_OKAY);
  endtask : mbox

  task automatic host(input logic [6:0] c, input logic blk, input logic g);
    cmq.push_back({3'h0, 1'b1, blk, g, c});
    i_host_mode <= 1'b1;
    i_host_cmd_valid <= 1'b1;
    i_host_cmd_code <= c;
    i_host_cmd_blk <= blk;
    @(posedge i_core_clk);
    i_host_cmd_valid <= 1'b0;
    i_host_mode <= 1'b0;
    @(posedge i_core_clk);
  endtask : host

  // back-to-back table reads keep the request high across them
  task automatic tbls(input int n);
    logic [1:0] sr, t;
    for (int i = 0; i < n; i++) begin
      sr = 2'($urandom_range(2));
      t = 2'($urandom_range(2));
      if (t == REGION_EXT || lk(t[0]) == LOCK_NONE) ok = 1'b1;
      else if (sr == REGION_EXT) ok = 1'b0;
      else if (lk(t[0]) == LOCK_HARD) ok = lk(sr[0]) == LOCK_HARD;
      else ok = 1'b1;
      tbq.push_back(ok ? fill[t * 8 +: 8] : TBL_BLOCKED_DATA);
      i_tbl_src <= sr;
      i_tbl_tgt <= t;
      i_tbl_req <= 1'b1;
      @(posedge i_core_clk);
    end
    i_tbl_req <= 1'b0;
    @(posedge i_core_clk);
  endtask : tbls

  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // ------------------------------------------------------------
  // monitor: oldest note against each result as it appears
  // ------------------------------------------------------------
  always @(posedge i_core_clk) begin
    if (o_s_axi_rvalid && i_s_axi_rready) begin
      ev = rdq.pop_front();
      `CHK("status", ev, {o_s_axi_rresp, o_s_axi_rdata[15:5]})
    end
    if (o_tbl_valid) begin
      ev = {5'h0, tbq.pop_front()};
      `CHK("table", ev[7:0], o_tbl_data)
    end
    if (o_flash_cmd_valid || o_cmd_refused) begin
      ev = cmq.pop_front();
      `CHK("command", ev[7:0], {o_flash_cmd_valid, o_flash_cmd_code})
      `CHK("cmd origin", ev[9:8], {o_flash_cmd_host, o_flash_cmd_blk})
    end
  end

  initial begin
    repeat (20000) @(posedge i_core_clk);
    miscompares++;
    conclude();
  end

  // ------------------------------------------------------------
  // main sequence: one pass per lock code
  // ------------------------------------------------------------
  initial begin
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = '0;
    {i_s_axi_arvalid, i_s_axi_rready, i_tbl_req, i_host_mode} = '0;
    {i_host_cmd_valid, i_host_cmd_blk, i_ext_access_n, i_rst_n} = '0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_fetch_region} = '0;
    {i_tbl_src, i_tbl_tgt, i_host_cmd_code} = '0;
    i_s_axi_wstrb = 4'hF;
    void'($urandom(32'h71A3));
    fill = 24'($urandom());
    repeat (5) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    wr(CONTROL_OFS, 32'h1, RESP_OKAY);
    wr(8'h40, 32'h0, RESP_DECERR);
    rd(8'h40, {RESP_DECERR, 11'h0});
    wr(STATUS_OFS, 32'hFFFFFFFF, RESP_OKAY);
    for (int c = 0; c < 8; c++) begin
      mbox(REGION_BLK0, CMD_CHIP_ERASE, 1'b0, 1'b1);
      if (c[2]) mbox(REGION_BLK0, CMD_PROG_LB1, 1'b0, 1'b1);
      if (c[1]) mbox(REGION_BLK0, CMD_PROG_LB2, 1'b0, 1'b1);
      if (c[0]) mbox(REGION_BLK0, CMD_PROG_LB3, 1'b0, 1'b1);
      st = exp_st(3'(c));
      rd(STATUS_OFS, {RESP_OKAY, st});
      tbls(4);
      s = 2'($urandom_range(2));
      b = 1'($urandom());
      case (c % 5)
        0: code = CMD_BLOCK_ERASE;
        1: code = CMD_SECTOR_ERASE;
        2: code = CMD_BYTE_PROG;
        3: code = CMD_BURST_PROG;
        default: code = CMD_BYTE_VERIFY;
      endcase
      ok = lk(b) == LOCK_NONE;
      mbox(s, code, b, ok || (lk(b) == LOCK_SOFT && s != REGION_EXT
        && s[0] != b));
      code = c[2] ? CMD_BYTE_VERIFY : CMD_BYTE_PROG;
      host(code, b, ok || (code == CMD_BYTE_VERIFY && st[9]));
      $display("test code %0d done", c);
    end
    host(CMD_CHIP_ERASE, 1'b1, 1'b1);
    rd(STATUS_OFS, {RESP_OKAY, exp_st(3'h0)});
    $display("test host erase done");
    repeat (4) @(posedge i_core_clk);
    conclude();
  end
endmodule : flash_security_lock_gate_test

bind fslg_lock_gate fslg_lock_gate_props props_u (.*);
